/* File: common/aux_io_pkg.sv */
package aux_io_pkg;
  typedef enum logic [1:0] {
    line_rx,
    line_analog,
    line_encoders,
    line_spare
  } line_mode_t;

  typedef struct packed {
    logic power;
    logic configured;
    logic suspended;
    logic dtr;
    logic rts;
  } usb_status_t;

  typedef struct packed {
    logic a_analog;
    logic b_analog;
    logic c_analog;
    logic d_analog;
    logic d_serial_rx;
    logic pot_analog;
  } line_use_t;

  typedef enum {
    reply_idle,
    reply_mode_arg,
    reply_high,
    reply_low
  } spi_state_t;
endpackage

/* File: common/aux_io_regs.svh */
// Purpose: Constants for the auxiliary I/O coprocessor with encoder counters.
// Assumes: Host is SPI master, mode 0, MSB first, 8-bit frames.
// Notes: Command byte values are local choices shared with the host.
// Notes on behaviour
// - Serial-receive mode: A, B, C analog; D is serial receive; TX always transmits.
// - Serial-receive mode forwards every byte received on D to the USB port.
// - Serial-receive mode at start and after every host reset.
// - All-analog mode: A, B, C and D are analog inputs.
// - Encoder mode: A/B form one quadrature pair, C/D another.
// - Slave-select flag is ORed into the mode and decoded separately.
// - Select disabled by default: the select line is the pot analog channel.
// - Select enabled and line high: ignore SPI bytes, leave MISO undriven.
// - Report USB power 1 when the connector supply is high.
// - Report 1 when USB is in the Configured state.
// - Report 1 while USB is suspended.
// - Report the virtual DTR line, default 0.
// - Report the virtual RTS line, default 0.
// - Encoder counts are signed 16-bit, positive limit 32767.
// - Count up when A/C changes first, down when B/D changes first.
// - Read-and-clear returns the count then zeroes it.
// - Both lines changing at once sets a sticky error, cleared on query.
// - Return a one-byte firmware version on request.
`ifndef AUX_IO_REGS_SVH
`define AUX_IO_REGS_SVH
`define CMD_SET_MODE      8'hc0
`define CMD_USB_POWER     8'ha0
`define CMD_USB_CONFIG    8'ha1
`define CMD_USB_SUSPEND   8'ha2
`define CMD_DTR           8'ha3
`define CMD_RTS           8'ha4
`define CMD_COUNT_1       8'hb0
`define CMD_COUNT_2       8'hb1
`define CMD_COUNT_CLR_1   8'hb2
`define CMD_COUNT_CLR_2   8'hb3
`define CMD_ERROR_1       8'hb4
`define CMD_ERROR_2       8'hb5
`define CMD_VERSION       8'hb6
`define MODE_RX           2'h0
`define MODE_ANALOG       2'h1
`define MODE_ENCODERS     2'h2
`define SELECT_FLAG_BIT   2
`define MODE_LSB          0
`define MODE_MSB          1
`define FIRMWARE_VERSION  8'h05
`define COUNT_MAX         16'h7fff
`define COUNT_MIN         16'h8000
`define BIT_LAST          3'h7
`endif

/* File: hw/aux_io_encoder_slave.sv */
// Purpose: SPI slave holding mode, USB status, version and two quadrature counters.
// Assumes: SPI mode 0, MSB first; host paces bytes; link pins are asynchronous.
// Notes: Counts are 16-bit, returned high byte first in the two following frames.
`timescale 1ns/1ps
`include "aux_io_regs.svh"

module aux_io_encoder_slave
  import aux_io_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // SPI link from the host
  input  wire logic        spi_sck,
  input  wire logic        spi_mosi,
  input  wire logic        spi_select_n,
  output logic             spi_miso_o,
  output logic             spi_miso_oe,
  // Host reset indication
  input  wire logic        host_reset,
  // Auxiliary lines
  input  wire logic        line_a,
  input  wire logic        line_b,
  input  wire logic        line_c,
  input  wire logic        line_d,
  output line_use_t        line_use,
  // Serial receive byte stream from line D to the USB port
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             usb_tx_valid,
  output logic [7:0]       usb_tx_byte,
  // USB status
  input  usb_status_t      usb_status,
  // Encoder counts for observation
  output logic [15:0]      count_first,
  output logic [15:0]      count_second
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync_sck, sync_mosi, sync_sel;
  logic [2:0] sync_a, sync_b, sync_c, sync_d;
  logic       sck_lvl, sel_lvl, a_lvl, b_lvl, c_lvl, d_lvl;
  logic       next_sck_lvl, next_sel_lvl;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_sck  <= 3'h0;
      sync_mosi <= 3'h0;
      sync_sel  <= 3'h7;
      sync_a    <= 3'h0;
      sync_b    <= 3'h0;
      sync_c    <= 3'h0;
      sync_d    <= 3'h0;
      sck_lvl   <= 1'b0;
      sel_lvl   <= 1'b1;
    end else begin
      sync_sck  <= {sync_sck[1:0], spi_sck};
      sync_mosi <= {sync_mosi[1:0], spi_mosi};
      sync_sel  <= {sync_sel[1:0], spi_select_n};
      sync_a    <= {sync_a[1:0], line_a};
      sync_b    <= {sync_b[1:0], line_b};
      sync_c    <= {sync_c[1:0], line_c};
      sync_d    <= {sync_d[1:0], line_d};
      sck_lvl   <= next_sck_lvl;
      sel_lvl   <= next_sel_lvl;
    end
  end

  always_comb begin
    next_sck_lvl = (sync_sck[2] == sync_sck[1]) ? sync_sck[1] : sck_lvl;
    next_sel_lvl = (sync_sel[2] == sync_sel[1]) ? sync_sel[1] : sel_lvl;
  end

  assign a_lvl = sync_a[2];
  assign b_lvl = sync_b[2];
  assign c_lvl = sync_c[2];
  assign d_lvl = sync_d[2];

  // ----------------------------------------------------------------
  // Mode and line assignment
  // ----------------------------------------------------------------
  line_mode_t mode, next_mode;
  logic       select_en, next_select_en;
  logic       cmd_set_mode;
  logic [7:0] cmd_arg;

  always_comb begin
    next_mode      = mode;
    next_select_en = select_en;
    if (host_reset) begin
      next_mode      = line_rx;
      next_select_en = 1'b0;
    end else if (cmd_set_mode) begin
      next_mode      = line_mode_t'(cmd_arg[`MODE_MSB:`MODE_LSB]);
      next_select_en = cmd_arg[`SELECT_FLAG_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode      <= line_rx;
      select_en <= 1'b0;
    end else begin
      mode      <= next_mode;
      select_en <= next_select_en;
    end
  end

  always_comb begin
    line_use.a_analog    = (mode != line_encoders);
    line_use.b_analog    = (mode != line_encoders);
    line_use.c_analog    = (mode != line_encoders);
    line_use.d_analog    = (mode == line_analog) || (mode == line_spare);
    line_use.d_serial_rx = (mode == line_rx);
    line_use.pot_analog  = !select_en;
  end

  // Received serial bytes only pass to USB in serial-receive mode.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      usb_tx_valid <= 1'b0;
      usb_tx_byte  <= 8'h00;
    end else begin
      usb_tx_valid <= rx_byte_valid && (mode == line_rx);
      usb_tx_byte  <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Quadrature decoders
  // ----------------------------------------------------------------
  logic enc_on;
  logic clr_first, clr_second, err_clr_first, err_clr_second;
  logic err_first, err_second;

  assign enc_on = (mode == line_encoders);

  quad_counter u_first (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .enable    (enc_on),
    .lead      (a_lvl),
    .lag       (b_lvl),
    .count_clr (clr_first),
    .err_clr   (err_clr_first),
    .count     (count_first),
    .err       (err_first)
  );

  quad_counter u_second (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .enable    (enc_on),
    .lead      (c_lvl),
    .lag       (d_lvl),
    .count_clr (clr_second),
    .err_clr   (err_clr_second),
    .count     (count_second),
    .err       (err_second)
  );

  // ----------------------------------------------------------------
  // SPI slave
  // ----------------------------------------------------------------
  logic       sck_prev, next_sck_prev;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift_in, next_shift_in;
  logic [7:0] shift_out, next_shift_out;
  logic [7:0] low_hold, next_low_hold;
  spi_state_t state, next_state;
  logic       rise, byte_done, active;
  logic [7:0] rx_full;
  logic [7:0] reply;
  logic [15:0] rd_count;

  // Select only gates traffic when the feature is enabled.
  assign active    = !select_en || !sel_lvl;
  assign rise      = sck_lvl && !sck_prev;
  assign rx_full   = {shift_in[6:0], sync_mosi[2]};
  assign byte_done = active && rise && (bit_cnt == `BIT_LAST);
  assign cmd_arg   = rx_full;
  assign cmd_set_mode = byte_done && (state == reply_mode_arg);

  always_comb begin
    clr_first      = 1'b0;
    clr_second     = 1'b0;
    err_clr_first  = 1'b0;
    err_clr_second = 1'b0;
    rd_count       = 16'h0000;
    reply          = 8'h00;
    if (rx_full == `CMD_USB_POWER) begin
      reply = {7'h00, usb_status.power};
    end else if (rx_full == `CMD_USB_CONFIG) begin
      reply = {7'h00, usb_status.configured};
    end else if (rx_full == `CMD_USB_SUSPEND) begin
      reply = {7'h00, usb_status.suspended};
    end else if (rx_full == `CMD_DTR) begin
      reply = {7'h00, usb_status.dtr};
    end else if (rx_full == `CMD_RTS) begin
      reply = {7'h00, usb_status.rts};
    end else if (rx_full == `CMD_VERSION) begin
      reply = `FIRMWARE_VERSION;
    end else if (rx_full == `CMD_ERROR_1) begin
      reply         = {7'h00, err_first};
      err_clr_first = byte_done && (state == reply_idle);
    end else if (rx_full == `CMD_ERROR_2) begin
      reply          = {7'h00, err_second};
      err_clr_second = byte_done && (state == reply_idle);
    end else if (rx_full == `CMD_COUNT_1 || rx_full == `CMD_COUNT_CLR_1) begin
      rd_count  = count_first;
      clr_first = byte_done && (state == reply_idle) && (rx_full == `CMD_COUNT_CLR_1);
    end else if (rx_full == `CMD_COUNT_2 || rx_full == `CMD_COUNT_CLR_2) begin
      rd_count   = count_second;
      clr_second = byte_done && (state == reply_idle) && (rx_full == `CMD_COUNT_CLR_2);
    end
  end

  always_comb begin
    next_sck_prev  = sck_lvl;
    next_bit_cnt   = bit_cnt;
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_low_hold  = low_hold;
    next_state     = state;
    if (!active) begin
      next_bit_cnt = 3'h0;
    end else if (rise) begin
      next_shift_in = rx_full;
      next_bit_cnt  = bit_cnt + 3'h1;
      // The next bit moves up on the rising edge, because the synchroniser delay
      // outlasts half an SCK period and a falling-edge shift would come too late.
      next_shift_out = {shift_out[6:0], 1'b0};
      if (byte_done) begin
        // Replies are staged for the next frame; the host's inter-byte gap covers this.
        next_shift_out = 8'h00;
        case (state)
          reply_idle: begin
            if (rx_full == `CMD_SET_MODE) begin
              next_state = reply_mode_arg;
            end else if (rx_full == `CMD_COUNT_1 || rx_full == `CMD_COUNT_2 ||
                         rx_full == `CMD_COUNT_CLR_1 || rx_full == `CMD_COUNT_CLR_2) begin
              next_shift_out = rd_count[15:8];
              next_low_hold  = rd_count[7:0];
              next_state     = reply_low;
            end else begin
              next_shift_out = reply;
            end
          end
          reply_low: begin
            next_shift_out = low_hold;
            next_state     = reply_idle;
          end
          default: begin
            next_state = reply_idle;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_prev  <= 1'b0;
      bit_cnt   <= 3'h0;
      shift_in  <= 8'h00;
      shift_out <= 8'h00;
      low_hold  <= 8'h00;
      state     <= reply_idle;
    end else begin
      sck_prev  <= next_sck_prev;
      bit_cnt   <= next_bit_cnt;
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
      low_hold  <= next_low_hold;
      state     <= next_state;
    end
  end

  assign spi_miso_o  = shift_out[7];
  assign spi_miso_oe = active;

endmodule

// One quadrature pair: lead changing first counts up, lag first counts down.
module quad_counter (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Control
  input  wire logic        enable,
  input  wire logic        lead,
  input  wire logic        lag,
  input  wire logic        count_clr,
  input  wire logic        err_clr,
  // State
  output logic [15:0]      count,
  output logic             err
);
  logic        lead_q, lag_q;
  logic [15:0] next_count;
  logic        next_err;
  logic        d_lead, d_lag, up, down;

  assign d_lead = lead ^ lead_q;
  assign d_lag  = lag ^ lag_q;
  // With X4 decoding, lead's level after its change differs from lag when lead moved first.
  assign up     = enable && (d_lead ^ d_lag) && ((d_lead && (lead != lag)) ||
                  (d_lag && (lead == lag)));
  assign down   = enable && (d_lead ^ d_lag) && !up;

  always_comb begin
    next_count = count;
    next_err   = err;
    if (count_clr) begin
      next_count = 16'h0000;
    end
    // Saturation keeps the sign honest; the host must clear before the limit.
    if (up && count != `COUNT_MAX) begin
      next_count = next_count + 16'h0001;
    end else if (down && count != `COUNT_MIN) begin
      next_count = next_count - 16'h0001;
    end
    if (err_clr) begin
      next_err = 1'b0;
    end
    if (enable && d_lead && d_lag) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lead_q <= 1'b0;
      lag_q  <= 1'b0;
      count  <= 16'h0000;
      err    <= 1'b0;
    end else begin
      lead_q <= lead;
      lag_q  <= lag;
      count  <= next_count;
      err    <= next_err;
    end
  end
endmodule

/* File: verification/aux_io_encoder_slave_assertions.sv */
// Purpose: Port-level checks for the auxiliary I/O block.
// Assumes: One clock domain; line_use follows the mode registers.
// Notes: Counts are judged by step size, as edge history is not visible here.
`timescale 1ns/1ps
module aux_io_encoder_slave_assertions
  import aux_io_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Observed ports
  input wire logic        host_reset,
  input wire logic        spi_select_n,
  input wire logic        spi_miso_oe,
  input wire line_use_t   line_use,
  input wire logic        rx_byte_valid,
  input wire logic [7:0]  rx_byte,
  input wire logic        usb_tx_valid,
  input wire logic [7:0]  usb_tx_byte,
  input wire logic [15:0] count_first,
  input wire logic [15:0] count_second
);
  default clocking dclk @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_fwd_rx_byte: assert property (
    rx_byte_valid && line_use.d_serial_rx |=> usb_tx_valid && usb_tx_byte == $past(rx_byte))
    else $error("serial byte not forwarded");
  a_fwd_only_rx: assert property (
    usb_tx_valid |-> $past(rx_byte_valid) && $past(line_use.d_serial_rx))
    else $error("forwarded byte without cause");
  a_host_reset_mode: assert property (
    host_reset |=> line_use == 6'h3b && spi_miso_oe)
    else $error("host reset left mode or select");
  a_rx_line_use: assert property (
    line_use.d_serial_rx |-> line_use.a_analog && line_use.b_analog && line_use.c_analog
      && !line_use.d_analog)
    else $error("serial mode line use wrong");
  a_pot_drives: assert property (
    line_use.pot_analog |-> spi_miso_oe)
    else $error("miso released with select off");
  a_idle_release: assert property (
    (!line_use.pot_analog && spi_select_n) [*5] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  a_step_first: assert property (
    count_first != $past(count_first) |-> (count_first - $past(count_first)) inside
      {16'h0001, 16'hffff} || count_first inside {16'h0000, 16'h0001, 16'hffff})
    else $error("first count jumped");
  a_step_second: assert property (
    count_second != $past(count_second) |-> (count_second - $past(count_second)) inside
      {16'h0001, 16'hffff} || count_second inside {16'h0000, 16'h0001, 16'hffff})
    else $error("second count jumped");
  a_count_sat: assert property (
    $past(count_first) == 16'h7fff |-> count_first != 16'h8000)
    else $error("count wrapped past limit");
  a_count_frozen: assert property (
    line_use.a_analog && $past(line_use.a_analog) |-> count_first == $past(count_first)
      || count_first == 16'h0000)
    else $error("count moved outside encoder mode");
endmodule

bind aux_io_encoder_slave aux_io_encoder_slave_assertions chk_u (
  .clk_sys(clk_sys), .rst(rst), .host_reset(host_reset), .spi_select_n(spi_select_n),
  .spi_miso_oe(spi_miso_oe), .line_use(line_use), .rx_byte_valid(rx_byte_valid),
  .rx_byte(rx_byte), .usb_tx_valid(usb_tx_valid), .usb_tx_byte(usb_tx_byte),
  .count_first(count_first), .count_second(count_second)
);

/* File: verification/aux_io_encoder_slave_test.sv */
// Purpose: Self-checking bench for the auxiliary I/O block.
// Assumes: Inputs change on falling clock edges; host model paces bytes.
// Notes: Drivers queue expected replies; a monitor matches them as they appear.
`timescale 1ns/1ps
`include "aux_io_regs.svh"
module aux_io_encoder_slave_test;
  import aux_io_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        host_reset = 1'b0;
  logic        line_a = 1'b0;
  logic        line_b = 1'b0;
  logic        line_c = 1'b0;
  logic        line_d = 1'b0;
  logic        rx_byte_valid = 1'b0;
  logic [7:0]  rx_byte = 8'h00;
  usb_status_t usb_status = '0;
  logic        flip = 1'b0;
  logic [31:0] seed = 32'h0ab1;
  int          n_fail = 0;
  int          n_checks = 0;
  int          n1;
  int          n2;
  logic [8:0]  e;
  logic [8:0]  exp_q[$];
  logic [7:0]  usb_q[$];
  logic [1:0]  gray[4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  wire         sck, mosi, select_n, miso_o, miso_oe, done, usb_tx_valid;
  wire [7:0]   host_rx, usb_tx_byte;
  wire [15:0]  count_first, count_second;
  line_use_t   line_use;
  // An undriven MISO toggles every cycle, so a stale bit cannot pass.
  wire         miso_line = miso_oe ? miso_o : flip;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) flip <= ~flip;
  aux_io_encoder_slave dut_u (
    .clk_sys(clk_sys), .rst(rst), .spi_sck(sck), .spi_mosi(mosi),
    .spi_select_n(select_n), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
    .host_reset(host_reset), .line_a(line_a), .line_b(line_b), .line_c(line_c),
    .line_d(line_d), .line_use(line_use), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .usb_tx_valid(usb_tx_valid), .usb_tx_byte(usb_tx_byte),
    .usb_status(usb_status), .count_first(count_first), .count_second(count_second)
  );
  spi_host_model host_u (
    .clk_sys(clk_sys), .spi_sck(sck), .spi_mosi(mosi), .spi_select_n(select_n),
    .miso_line(miso_line), .done(done), .rx(host_rx)
  );
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] tx, input logic chk, input logic [7:0] exp,
                      input logic other);
    exp_q.push_back({chk, exp});
    host_u.xfer(tx, other);
  endtask
  task automatic ask(input logic [7:0] c, input logic [7:0] exp);
    xfer(c, 1'b0, 8'h00, 1'b0);
    xfer(8'h00, 1'b1, exp, 1'b0);
  endtask
  task automatic ask16(input logic [7:0] c, input logic [15:0] exp);
    ask(c, exp[15:8]);
    xfer(8'h00, 1'b1, exp[7:0], 1'b0);
  endtask
  task automatic set_mode(input logic [7:0] m);
    xfer(`CMD_SET_MODE, 1'b0, 8'h00, 1'b0);
    xfer(m, 1'b0, 8'h00, 1'b0);
  endtask
  task automatic step(input logic [3:0] v);
    {line_a, line_b, line_c, line_d} = v;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic pulse_rx(input logic fwd);
    for (int i = 0; i < 2; i++) begin
      seed = xorshift(seed);
      rx_byte = seed[7:0];
      rx_byte_valid = 1'b1;
      if (fwd) usb_q.push_back(seed[7:0]);
      @(negedge clk_sys);
    end
    rx_byte_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic stop_test;
    $display("checks %0d, failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------
  // Monitor, stimulus and watchdog
  // --------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (done === 1'b1) begin
      e = exp_q.pop_front();
      if (e[8]) check(host_rx, e[7:0]);
    end
    if (usb_tx_valid !== 1'b0) begin
      check(usb_tx_byte, usb_q.size() ? usb_q.pop_front() : 16'hffff);
    end
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(line_use, 6'h3b);
    check(count_first, 16'h0000);
    ask(`CMD_VERSION, `FIRMWARE_VERSION);
    pulse_rx(1'b1);
    for (int k = 0; k < 5; k++) begin
      seed = xorshift(seed);
      usb_status = seed[4:0];
      ask(8'(`CMD_USB_POWER + k), {7'h00, seed[4 - k]});
    end
    set_mode({6'h00, `MODE_ANALOG});
    check(line_use, 6'h3d);
    pulse_rx(1'b0);
    for (int i = 0; i < 4; i++) step({gray[i], 2'b00});
    check(count_first, 16'h0000);
    set_mode({6'h00, `MODE_ENCODERS});
    check(line_use, 6'h01);
    seed = xorshift(seed);
    n1 = seed[3:0] + 1;
    n2 = seed[7:4] + 1;
    for (int i = 0; i < n1; i++) step({gray[i % 4], line_c, line_d});
    for (int i = 0; i < n2; i++) step({line_a, line_b, gray[i % 4][0], gray[i % 4][1]});
    check(count_first, 16'(n1));
    check(count_second, 16'(-n2));
    ask16(`CMD_COUNT_1, 16'(n1));
    ask16(`CMD_COUNT_CLR_2, 16'(-n2));
    check(count_second, 16'h0000);
    ask16(`CMD_COUNT_2, 16'h0000);
    step({~line_a, ~line_b, line_c, line_d});
    ask(`CMD_ERROR_1, 8'h01);
    ask(`CMD_ERROR_1, 8'h00);
    ask(`CMD_ERROR_2, 8'h00);
    set_mode({5'h00, 1'b1, `MODE_ENCODERS});
    check(line_use, 6'h00);
    xfer(`CMD_SET_MODE, 1'b0, 8'h00, 1'b1);
    check(miso_oe, 1'b0);
    ask(`CMD_VERSION, `FIRMWARE_VERSION);
    host_reset = 1'b1;
    @(negedge clk_sys);
    host_reset = 1'b0;
    @(negedge clk_sys);
    check(line_use, 6'h3b);
    xfer(`CMD_VERSION, 1'b0, 8'h00, 1'b1);
    xfer(8'h00, 1'b1, `FIRMWARE_VERSION, 1'b1);
    pulse_rx(1'b1);
    repeat (10) @(negedge clk_sys);
    check(exp_q.size() + usb_q.size(), 16'h0000);
    stop_test();
  end
  initial begin
    #1000000;
    n_fail++;
    stop_test();
  end
endmodule

/* File: verification/spi_host_model.sv */
// Purpose: Host SPI master, mode 0, MSB first, paced by the system clock.
// Assumes: SCK half period of four system clocks, 320 ns per bit.
// Notes: SCK stays low and select high between frames.
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input wire logic  clk_sys,
  // SPI link
  output logic      spi_sck,
  output logic      spi_mosi,
  output logic      spi_select_n,
  input wire logic  miso_line,
  // Frame result
  output logic      done,
  output logic [7:0] rx
);
  initial begin
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
    spi_select_n = 1'b1;
    done = 1'b0;
    rx = 8'h00;
  end
  // --------------------------------------------------------------
  // Frame exchange
  // --------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, input logic other);
    logic [7:0] r;
    @(negedge clk_sys);
    spi_select_n = other;
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = tx[i];
      repeat (4) @(negedge clk_sys);
      spi_sck = 1'b1;
      r[i] = miso_line;
      repeat (4) @(negedge clk_sys);
      spi_sck = 1'b0;
    end
    rx = r;
    done = 1'b1;
    @(negedge clk_sys);
    done = 1'b0;
    spi_select_n = 1'b1;
    // A released MOSI shows the inverse bit, so stale data never passes for real data.
    spi_mosi = ~tx[0];
    repeat (30) @(negedge clk_sys);
  endtask
endmodule
